// File: design/servo_link_status_monitor.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "servo_link_status_monitor_regs.svh"

module servo_link_status_monitor (
  input  wire logic                                     i_clk_sys,         // 100 MHz clock
  input  wire logic                                     i_rst_b,           // async reset, low
  input  wire logic [3:0]                               i_addr,            // register index
  input  wire servo_link_status_monitor_pkg::word_t     i_wdata,           // write data
  input  wire logic                                     i_wr,              // write strobe
  input  wire logic                                     i_rd,              // read strobe
  output servo_link_status_monitor_pkg::word_t          o_rdata,           // read data, next cycle
  input  wire servo_link_status_monitor_pkg::axis_vec_t i_amp_comm_ok,     // per-axis comm ok pin
  input  wire logic                                     i_link_fault,      // host link fault pulse
  input  wire logic [2:0]                               i_link_fault_code, // fault code 1..5
  input  wire logic                                     i_link_normal,     // link resumed pulse
  output logic                                          o_irq              // level interrupt
);

  // register map on the plain port, one 16-bit word per index
  //   0  presence of axes 1-16, bit 0 is axis 1
  //   1  presence of axes 17-32, bit 0 is axis 17
  //   2  host link error word, last fault code held
  //   3  operation cycle actually run, in microseconds
  //   4  used-axis mask for axes 1-16, all ones after reset
  //   5  used-axis mask for axes 17-32, all ones after reset
  //   6  cycle selection in bits 2:0, automatic after reset
  //   7  interrupt status in bits 2:0, write ones to clear
  //   8  interrupt mask in bits 2:0, all masked after reset
  //   9  indicator word
  //   10 to 15 unmapped: read as zero, writes dropped
  // indices 0 to 3 and 9 are status; the program cannot write them
  // the register index is a word index, not a byte address

  // access timing
  //   a write takes effect at its strobe edge
  //   address and write data are looked at only beside a strobe
  //   read data stand in the cycle after the strobe and only there;
  //   in every other cycle they are zero, so a wired-or bus
  //   of several such blocks needs no extra gating
  //   reads and writes may follow each other with no gap
  //   the port never stalls the program; there is no wait state
  //   a strobe to an unmapped index is answered like any other

  // presence bitmap
  //   each axis pin passes two sync stages, then the bitmap register
  //   a pin change shows in the bitmap three edges later
  //   reset clears the bitmap, so every used axis is probed again
  //   an amplifier that stops talking drops its bit on its own; no
  //   reset is needed, and one that starts talking sets it the same way
  //   an axis masked out as unused reads zero whatever its pin shows
  //   bit 15 of the low word is axis 16, of the high word axis 32
  //   a pin that toggles faster than the clock can be missed entirely

  // interrupt status bits
  //   bit 0  presence bitmap changed, any axis, either direction
  //   bit 1  host link fault taken
  //   bit 2  host link resumed, with no fault in the same cycle
  //   the change bit trails the bitmap by one edge
  // a bit set and cleared in one cycle stays set: no event is lost to a
  // racing clear, at the cost of an occasional extra pass of the handler
  // the interrupt pin is high while any status bit is set and unmasked,
  // and it follows a mask write from the next cycle

  // cycle selection codes in index 6
  //   0 automatic, 1 0.4 ms, 2 0.8 ms, 3 1.7 ms
  //   4 3.5 ms, 5 7.1 ms, 6 14.2 ms
  //   7 is no valid choice and falls back to automatic
  // automatic runs 0.4 ms up to 8 used axes, 0.8 ms up to 16, else 1.7 ms
  // a network with nine or more talking amplifiers cannot be served in
  // 0.4 ms; the word then shows 0.8 ms, the cycle really run
  // axes 1-16 form the first network and axes 17-32 the second
  // the cycle word trails its inputs by one edge; reset loads it with 0.4 ms,
  // which it keeps until the first edge after reset

  // host link error word
  //   a fault pulse stores its code, zero extended to the word
  //   codes 1 to 5 are the defined faults; others are stored as given
  //   a resume pulse returns the word to zero, no error
  //   a resume in the cycle of a fault is dropped: the fault wins,
  //   since it is the newer and the more useful news
  //   a second fault overwrites the first; only the last code is kept
  //   reading the word does not clear it

  // indicator word, two bits to each indicator: 0 off, 1 lit, 2 flashing
  //   bits 1:0   amplifier network: off while no amplifier talks, lit
  //              when every used axis talks, flashing when only some do
  //   bits 3:2   host link: off while no error code is held, else flashing
  //   bits 15:4  read as zero

  // typical program sequences
  //   bring-up: write the used masks, then the cycle selection, then
  //   wait a few cycles before reading presence or the cycle word
  //   interrupt: read status, handle each set bit, write the same value
  //   back to clear exactly what was handled
  //   polling: the link error word may be read at any time

  // limitations
  //   the used-axis mask stands in for the system configuration;
  //   nothing here checks that a used axis exists on its network
  //   reset is the only controller reset; there is no soft reset
  //   right after a mask write the presence and indicator words may
  //   show the old state for a cycle

  servo_link_status_monitor_pkg::monitor_state_t s_reg;
  servo_link_status_monitor_pkg::monitor_state_t s_next;
  servo_link_status_monitor_pkg::axis_vec_t      presence;
  logic                                          pres_change;
  logic [5:0]                                    used_count;
  logic [4:0]                                    net0_amps;
  logic [4:0]                                    net1_amps;
  logic                                          net_dense;
  servo_link_status_monitor_pkg::word_t          cycle_sel_us;
  logic [`IRQ_W-1:0]                             irq_events;
  logic [1:0]                                    amp_ind;
  logic [1:0]                                    link_ind;
  servo_link_status_monitor_pkg::word_t          indicator_word;

  // per-axis presence bitmap lives in the tracker
  axis_presence_tracker axis_presence_tracker_inst (
    .i_clk_sys     (i_clk_sys),
    .i_rst_b       (i_rst_b),
    .i_amp_comm_ok (i_amp_comm_ok),
    .i_axis_used   (s_reg.used),
    .o_presence    (presence),
    .o_change      (pres_change)
  );

  // count of set bits in a half word
  function automatic logic [4:0] count16(input logic [15:0] v);
    logic [4:0] n;
    n = '0;
    for (int k = 0; k < 16; k++) begin
      n = n + 5'(v[k]);
    end
    return n;
  endfunction : count16

  // axes 1-16 ride the first amplifier network, 17-32 the second
  always_comb begin
    used_count = 6'(count16(s_reg.used[15:0])) + 6'(count16(s_reg.used[31:16]));
    net0_amps  = count16(presence[15:0]);
    net1_amps  = count16(presence[31:16]);
    net_dense  = (net0_amps >= `NET_DENSE_AMPS) || (net1_amps >= `NET_DENSE_AMPS);
  end

  // cycle actually used; dense network cannot keep up with 0.4 ms
  always_comb begin
    cycle_sel_us = `CYC_US_0P4;
    case (s_reg.cycle_cfg)
      servo_link_status_monitor_pkg::CYC_0P4:  cycle_sel_us = `CYC_US_0P4;
      servo_link_status_monitor_pkg::CYC_0P8:  cycle_sel_us = `CYC_US_0P8;
      servo_link_status_monitor_pkg::CYC_1P7:  cycle_sel_us = `CYC_US_1P7;
      servo_link_status_monitor_pkg::CYC_3P5:  cycle_sel_us = `CYC_US_3P5;
      servo_link_status_monitor_pkg::CYC_7P1:  cycle_sel_us = `CYC_US_7P1;
      servo_link_status_monitor_pkg::CYC_14P2: cycle_sel_us = `CYC_US_14P2;
      default: begin
        // automatic: few axes run fast, many axes slower
        if (used_count <= `AUTO_AXES_FAST) begin
          cycle_sel_us = `CYC_US_0P4;
        end else if (used_count <= `AUTO_AXES_MID) begin
          cycle_sel_us = `CYC_US_0P8;
        end else begin
          cycle_sel_us = `CYC_US_1P7;
        end
      end
    endcase
    if (net_dense && (cycle_sel_us == `CYC_US_0P4)) begin
      cycle_sel_us = `CYC_US_0P8;
    end
  end

  // interrupt-worthy events of this cycle
  always_comb begin
    irq_events                 = '0;
    irq_events[`IRQ_PRES_CHG]  = pres_change;
    irq_events[`IRQ_LINK_ERR]  = i_link_fault;
    irq_events[`IRQ_LINK_OK]   = i_link_normal & ~i_link_fault;
  end

  // indicator codes from live status; a partly populated network flashes
  // so that one missing amplifier among many is still noticed
  always_comb begin
    if (presence == '0) begin
      amp_ind = `IND_OFF;
    end else if (presence == s_reg.used) begin
      amp_ind = `IND_LIT;
    end else begin
      amp_ind = `IND_FLASH;
    end
    if (s_reg.link_err == `LINK_ERR_NONE) begin
      link_ind = `IND_OFF;
    end else begin
      link_ind = `IND_FLASH;
    end
    indicator_word = {`IND_PAD, link_ind, amp_ind};
  end

  // next state: status words, config writes, read data, interrupt
  always_comb begin
    s_next          = s_reg;
    s_next.rdata    = `RST_WORD;
    s_next.cycle_us = cycle_sel_us;

    // fault wins over a resume seen in the same cycle
    if (i_link_fault) begin
      s_next.link_err = servo_link_status_monitor_pkg::word_t'(i_link_fault_code);
    end else if (i_link_normal) begin
      s_next.link_err = `LINK_ERR_NONE;
    end

    // status words take no writes; only config, mask and w1c
    if (i_wr) begin
      if (i_addr == `ADDR_USED_LO) begin
        s_next.used[15:0] = i_wdata;
      end else if (i_addr == `ADDR_USED_HI) begin
        s_next.used[31:16] = i_wdata;
      end else if (i_addr == `ADDR_CYCLE_CFG) begin
        s_next.cycle_cfg =
          servo_link_status_monitor_pkg::cycle_sel_t'(i_wdata[`CYCLE_CFG_W-1:0]);
      end else if (i_addr == `ADDR_IRQ_STATUS) begin
        s_next.irq_status = s_reg.irq_status & ~i_wdata[`IRQ_W-1:0];
      end else if (i_addr == `ADDR_IRQ_MASK) begin
        s_next.irq_mask = i_wdata[`IRQ_W-1:0];
      end
    end

    // set after clear so an event in the clearing cycle survives
    s_next.irq_status = s_next.irq_status | irq_events;
    s_next.irq        = |(s_next.irq_status & s_next.irq_mask);

    // read data stand for exactly one cycle after the strobe
    if (i_rd) begin
      if (i_addr == `ADDR_PRES_LO) begin
        s_next.rdata = presence[15:0];
      end else if (i_addr == `ADDR_PRES_HI) begin
        s_next.rdata = presence[31:16];
      end else if (i_addr == `ADDR_LINK_ERR) begin
        s_next.rdata = s_reg.link_err;
      end else if (i_addr == `ADDR_CYCLE) begin
        s_next.rdata = s_reg.cycle_us;
      end else if (i_addr == `ADDR_USED_LO) begin
        s_next.rdata = s_reg.used[15:0];
      end else if (i_addr == `ADDR_USED_HI) begin
        s_next.rdata = s_reg.used[31:16];
      end else if (i_addr == `ADDR_CYCLE_CFG) begin
        s_next.rdata = servo_link_status_monitor_pkg::word_t'(s_reg.cycle_cfg);
      end else if (i_addr == `ADDR_IRQ_STATUS) begin
        s_next.rdata = servo_link_status_monitor_pkg::word_t'(s_reg.irq_status);
      end else if (i_addr == `ADDR_IRQ_MASK) begin
        s_next.rdata = servo_link_status_monitor_pkg::word_t'(s_reg.irq_mask);
      end else if (i_addr == `ADDR_INDICATOR) begin
        s_next.rdata = indicator_word;
      end
    end
  end

  // single state register for the monitor top; the tracker keeps its own
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_reg.link_err   <= `LINK_ERR_NONE;
      s_reg.cycle_us   <= `CYC_US_0P4;
      s_reg.used       <= {`RST_USED, `RST_USED};
      s_reg.cycle_cfg  <= servo_link_status_monitor_pkg::CYC_AUTO;
      s_reg.irq_status <= `RST_IRQ;
      s_reg.irq_mask   <= `RST_IRQ;
      s_reg.irq        <= 1'b0;
      s_reg.rdata      <= `RST_WORD;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rdata = s_reg.rdata;
  assign o_irq   = s_reg.irq;

endmodule : servo_link_status_monitor

// File: design/servo_link_status_monitor_regs.svh
`ifndef SERVO_LINK_STATUS_MONITOR_REGS_SVH
`define SERVO_LINK_STATUS_MONITOR_REGS_SVH

// register indices on the plain register port
`define ADDR_PRES_LO      4'h0
`define ADDR_PRES_HI      4'h1
`define ADDR_LINK_ERR     4'h2
`define ADDR_CYCLE        4'h3
`define ADDR_USED_LO      4'h4
`define ADDR_USED_HI      4'h5
`define ADDR_CYCLE_CFG    4'h6
`define ADDR_IRQ_STATUS   4'h7
`define ADDR_IRQ_MASK     4'h8
`define ADDR_INDICATOR    4'h9

// reset values
`define RST_WORD          16'h0000
`define RST_USED          16'hffff
`define RST_CYCLE_CFG     3'h0
`define RST_IRQ           3'h0

// cycle lengths in microseconds
`define CYC_US_0P4        16'h0190
`define CYC_US_0P8        16'h0320
`define CYC_US_1P7        16'h06a4
`define CYC_US_3P5        16'h0dac
`define CYC_US_7P1        16'h1bbc
`define CYC_US_14P2       16'h3778

// axis count thresholds
`define AUTO_AXES_FAST    6'h08
`define AUTO_AXES_MID     6'h10
`define NET_DENSE_AMPS    5'h09

// host link error codes
`define LINK_ERR_NONE     16'h0000

// indicator codes, two bits to each indicator
`define IND_OFF           2'h0
`define IND_LIT           2'h1
`define IND_FLASH         2'h2
`define IND_PAD           12'h000

// interrupt bit positions
`define IRQ_PRES_CHG      0
`define IRQ_LINK_ERR      1
`define IRQ_LINK_OK       2

// field widths
`define CYCLE_CFG_W       3
`define IRQ_W             3

`endif

// File: design/servo_link_status_monitor_pkg.sv
package servo_link_status_monitor_pkg;

  typedef logic [15:0] word_t;
  typedef logic [31:0] axis_vec_t;

  // operation cycle selection written by software
  typedef enum logic [2:0] {
    CYC_AUTO = 3'b000,
    CYC_0P4  = 3'b001,
    CYC_0P8  = 3'b010,
    CYC_1P7  = 3'b011,
    CYC_3P5  = 3'b100,
    CYC_7P1  = 3'b101,
    CYC_14P2 = 3'b110,
    CYC_RSVD = 3'b111
  } cycle_sel_t;

  // state of the presence tracker
  typedef struct packed {
    axis_vec_t sync1;
    axis_vec_t sync2;
    axis_vec_t pres;
    logic      change;
  } tracker_state_t;

  // state of the monitor top
  typedef struct packed {
    word_t      link_err;
    word_t      cycle_us;
    axis_vec_t  used;
    cycle_sel_t cycle_cfg;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic       irq;
    word_t      rdata;
  } monitor_state_t;

endpackage : servo_link_status_monitor_pkg

// File: design/axis_presence_tracker.sv
`timescale 1ns/1ps
`include "servo_link_status_monitor_regs.svh"

module axis_presence_tracker (
  input  wire logic                                     i_clk_sys,      // system clock
  input  wire logic                                     i_rst_b,        // async reset, low
  input  wire servo_link_status_monitor_pkg::axis_vec_t i_amp_comm_ok,  // amp talks, async
  input  wire servo_link_status_monitor_pkg::axis_vec_t i_axis_used,    // configured axes
  output servo_link_status_monitor_pkg::axis_vec_t       o_presence,    // presence bitmap
  output logic                                          o_change        // bitmap changed
);

  servo_link_status_monitor_pkg::tracker_state_t s_reg;
  servo_link_status_monitor_pkg::tracker_state_t s_next;
  servo_link_status_monitor_pkg::axis_vec_t      pres_next;

  // one presence cell per axis, continuous tracking both ways
  generate
    for (genvar i = 0; i < 32; i++) begin : g_axis
      assign pres_next[i] = i_axis_used[i] & s_reg.sync2[i];
    end
  endgenerate

  // first sync stage feeds only the second
  always_comb begin
    s_next        = s_reg;
    s_next.sync1  = i_amp_comm_ok;
    s_next.sync2  = s_reg.sync1;
    s_next.pres   = pres_next;
    s_next.change = (pres_next != s_reg.pres);
  end

  // bitmap starts empty, so every axis is probed after reset
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_presence = s_reg.pres;
  assign o_change   = s_reg.change;

endmodule : axis_presence_tracker

// File: verif/servo_link_status_monitor_assertions.sv
`timescale 1ns/1ps
module slsm_checker (
  input wire logic        i_clk_sys,         // clock
  input wire logic        i_rst_b,           // reset, low
  input wire logic [3:0]  i_addr,            // index
  input wire logic [15:0] i_wdata,           // write data
  input wire logic        i_wr,              // write
  input wire logic        i_rd,              // read
  input wire logic [15:0] o_rdata,           // read data
  input wire logic [31:0] i_amp_comm_ok,     // amp pins
  input wire logic        i_link_fault,      // fault pulse
  input wire logic [2:0]  i_link_fault_code, // fault code
  input wire logic        i_link_normal,     // resume pulse
  input wire logic        o_irq              // interrupt
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  localparam logic [15:0] cyc_lut [8] = '{16'h0000, 16'h0190, 16'h0320, 16'h06a4,
                                          16'h0dac, 16'h1bbc, 16'h3778, 16'h0000};
  logic [31:0] used_q;
  logic [2:0]  mask_q;
  logic [2:0]  cfg_q;
  logic [3:0]  calm_q;
  logic [15:0] err_q;
  // shadow of software settings; calm counts quiet cycles so sync latency has passed
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      used_q <= 32'hffffffff;
      mask_q <= 3'h0;
      cfg_q  <= 3'h0;
      calm_q <= 4'h0;
      err_q  <= 16'h0000;
    end else begin
      // error word shadow from the link pulses; a fault beats a resume
      if (i_link_fault) err_q <= {13'h0000, i_link_fault_code};
      else if (i_link_normal) err_q <= 16'h0000;
      if (i_wr && i_addr == 4'h4) used_q[15:0] <= i_wdata;
      if (i_wr && i_addr == 4'h5) used_q[31:16] <= i_wdata;
      if (i_wr && i_addr == 4'h6) cfg_q <= i_wdata[2:0];
      if (i_wr && i_addr == 4'h8) mask_q <= i_wdata[2:0];
      if (i_wr && i_addr > 4'h3 && i_addr < 4'h7 || i_amp_comm_ok != $past(i_amp_comm_ok))
        calm_q <= 4'h0;
      else if (calm_q != 4'hf)
        calm_q <= calm_q + 4'h1;
    end
  end
  a_pres_low: assert property (i_rd && i_addr == 4'h0 && calm_q > 4'h3 |=>
    o_rdata == ($past(i_amp_comm_ok[15:0]) & $past(used_q[15:0])))
    else $error("presence low word differs from pins");
  a_pres_high: assert property (i_rd && i_addr == 4'h1 && calm_q > 4'h3 |=>
    o_rdata == ($past(i_amp_comm_ok[31:16]) & $past(used_q[31:16])))
    else $error("presence high word differs from pins");
  a_cycle_fixed: assert property (i_rd && i_addr == 4'h3 && calm_q > 4'h3 &&
    cfg_q > 3'h1 && cfg_q < 3'h7 |=> o_rdata == cyc_lut[$past(cfg_q)])
    else $error("fixed cycle word wrong");
  a_err_code: assert property (i_rd && i_addr == 4'h2 && err_q != 16'h0000 |=>
    o_rdata == $past(err_q))
    else $error("link error word lacks fault code");
  a_err_clear: assert property (i_rd && i_addr == 4'h2 && err_q == 16'h0000 |=>
    o_rdata == 16'h0000)
    else $error("link error word not cleared on resume");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside answer cycle");
  a_irq_fault: assert property (i_link_fault && mask_q[1] && !i_wr |-> ##[1:2] o_irq)
    else $error("unmasked fault gave no interrupt");
  a_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !o_irq)
    else $error("interrupt with all events masked");
  c_fault: cover property (i_link_fault ##1 o_irq);
  c_dense: cover property (i_rd && i_addr == 4'h3 ##1 o_rdata == 16'h0320);
  c_pres: cover property (i_rd && i_addr == 4'h1 ##1 o_rdata != 16'h0000);
endmodule : slsm_checker
bind servo_link_status_monitor slsm_checker slsm_checker_inst (.i_clk_sys, .i_rst_b, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_amp_comm_ok, .i_link_fault, .i_link_fault_code,
  .i_link_normal, .o_irq);

// File: verif/amp_net_model.sv
`timescale 1ns/1ps
module amp_net_model (
  input  wire logic [31:0] i_powered,  // amp power per axis
  input  wire logic [1:0]  i_cable_ok, // cable per network
  output logic      [31:0] o_comm_ok   // normal talk per axis
);
  // an amp talks only while powered and its network cable is intact
  assign o_comm_ok = i_powered & {{16{i_cable_ok[1]}}, {16{i_cable_ok[0]}}};
endmodule : amp_net_model

// File: verif/servo_link_status_monitor_tb_top.sv
`timescale 1ns/1ps
module servo_link_status_monitor_tb_top;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [31:0] comm_ok;
  logic [31:0] powered = 32'h00000000;
  logic [1:0]  cable_ok = 2'h3;
  logic        i_link_fault = 1'b0;
  logic [2:0]  i_link_fault_code = 3'h0;
  logic        i_link_normal = 1'b0;
  logic        o_irq;
  logic        rd_seen = 1'b0;
  logic [15:0] exp_q[$];
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  integer      seed = 32'hb665;
  logic [31:0] used;
  logic [31:0] pres;
  logic [2:0]  cfg;
  logic [15:0] rst_val [10] = '{16'h0000, 16'h0000, 16'h0000, 16'h06a4, 16'hffff,
                                16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] cyc_us [8] = '{16'h0000, 16'h0190, 16'h0320, 16'h06a4, 16'h0dac,
                              16'h1bbc, 16'h3778, 16'h0000};
  servo_link_status_monitor servo_link_status_monitor_inst (.i_clk_sys, .i_rst_b, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_amp_comm_ok(comm_ok), .i_link_fault,
    .i_link_fault_code, .i_link_normal, .o_irq);
  amp_net_model amp_net_model_inst (.i_powered(powered), .i_cable_ok(cable_ok),
    .o_comm_ok(comm_ok));
  initial forever #5 i_clk_sys = ~i_clk_sys;
  // auto picks by configured axes; a dense network lifts 0.4 ms to 0.8 ms
  function automatic logic [15:0] exp_cycle(input logic [2:0] c, input logic [31:0] u,
                                            input logic [31:0] p);
    logic [15:0] v;
    v = (c != 3'h0 && c != 3'h7) ? cyc_us[c] : ($countones(u) <= 8) ? 16'h0190 :
        ($countones(u) <= 16) ? 16'h0320 : 16'h06a4;
    if (v == 16'h0190 && ($countones(p[15:0]) > 8 || $countones(p[31:16]) > 8))
      v = 16'h0320;
    return v;
  endfunction : exp_cycle
  // network off with none talking, lit with every used amp, else flashing
  function automatic logic [15:0] exp_ind(input logic [31:0] p, input logic [31:0] u,
                                          input logic e);
    return {12'h000, e ? 2'h2 : 2'h0, p == 32'h0 ? 2'h0 : p == u ? 2'h1 : 2'h2};
  endfunction : exp_ind
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    checks++;
    if (seen !== expd) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  // the expected answer is noted when the read is issued
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
  endtask : rd
  task automatic link(input logic f, input logic [2:0] c, input logic n);
    @(posedge i_clk_sys);
    i_link_fault <= f;
    i_link_fault_code <= c;
    i_link_normal <= n;
    @(posedge i_clk_sys);
    i_link_fault <= 1'b0;
    i_link_normal <= 1'b0;
  endtask : link
  // read answers stand one cycle only, so they are matched at the next edge
  always @(posedge i_clk_sys) begin
    if (rd_seen) check(o_rdata, exp_q.pop_front());
    rd_seen <= i_rd;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    // status words 0 to 3 ignore writes; indices 0 to 9 then show their reset values, index 3 the 1.7 ms auto cycle for 32 used axes
    for (int a = 0; a < 4; a++) wr(a[3:0], 16'($random(seed)));
    for (int a = 0; a < 10; a++) rd(a[3:0], rst_val[a]);
    // corner loads first, then random ones; amps come and go both ways
    for (int i = 0; i < 12; i++) begin
      used = i == 0 ? 32'h000001ff : i == 1 ? 32'h000000ff : $random(seed);
      cfg = i == 0 ? 3'h1 : i == 1 ? 3'h0 : 3'($random(seed));
      @(posedge i_clk_sys);
      powered <= i < 2 ? 32'hffffffff : $random(seed);
      cable_ok <= i < 2 ? 2'h3 : 2'($random(seed));
      wr(4'h4, used[15:0]);
      wr(4'h5, used[31:16]);
      wr(4'h6, {13'h0000, cfg});
      repeat (6) @(posedge i_clk_sys);
      pres = powered & {{16{cable_ok[1]}}, {16{cable_ok[0]}}} & used;
      rd(4'h0, pres[15:0]);
      rd(4'h1, pres[31:16]);
      rd(4'h3, exp_cycle(cfg, used, pres));
      rd(4'h9, exp_ind(pres, used, 1'b0));
    end
    wr(4'h7, 16'h0007);
    wr(4'h8, 16'h0002);
    for (int c = 1; c < 6; c++) begin
      link(1'b1, c[2:0], 1'b0);
      rd(4'h2, 16'(c));
      check({15'h0000, o_irq}, 16'h0001);
      rd(4'h9, exp_ind(pres, used, 1'b1));
      link(1'b0, 3'h0, 1'b1);
      rd(4'h2, 16'h0000);
      rd(4'h9, exp_ind(pres, used, 1'b0));
    end
    rd(4'h7, 16'h0006);
    wr(4'h7, 16'h0006);
    rd(4'h7, 16'h0000);
    check({15'h0000, o_irq}, 16'h0000);
    // masked fault stays quiet until unmasked; fault wins over resume
    wr(4'h8, 16'h0000);
    link(1'b1, 3'h5, 1'b1);
    rd(4'h2, 16'h0005);
    check({15'h0000, o_irq}, 16'h0000);
    wr(4'h8, 16'h0002);
    @(posedge i_clk_sys);
    check({15'h0000, o_irq}, 16'h0001);
    repeat (3) @(posedge i_clk_sys);
    summarize();
  end
endmodule : servo_link_status_monitor_tb_top
